// file: src/bcdr_pkg.sv
package bcdr_pkg;
   // ------------------------------------------------------------
   // register indexes and byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0]  IDX_BUFCTL    = 8'h53;
   localparam logic [7:0]  IDX_ROWTYPE   = 8'h55;
   localparam logic [11:0] ADDR_BUFCTL   = {2'h0, IDX_BUFCTL, 2'h0};
   localparam logic [11:0] ADDR_ROWTYPE  = {2'h0, IDX_ROWTYPE, 2'h0};
   localparam int          ADDR_W        = 12;

   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  BUFCTL_RST     = 8'h83;
   localparam logic [7:0]  BUFCTL_RW_MASK = 8'h60;
   localparam int          BUFCTL_IDE_BIT = 6;
   localparam int          BUFCTL_WC_BIT  = 5;
   localparam logic [15:0] ROWTYPE_RST    = 16'h0000;
   localparam int          ROW_COUNT     = 8;
   localparam int          ROW_SEL_W     = 3;

   // ------------------------------------------------------------
   // row type codes
   // ------------------------------------------------------------
   localparam logic [1:0]  ROW_EDO       = 2'h0;
   localparam logic [1:0]  ROW_RSVD      = 2'h1;
   localparam logic [1:0]  ROW_SDRAM     = 2'h2;
   localparam logic [1:0]  ROW_EMPTY     = 2'h3;

   // ------------------------------------------------------------
   // ahb transfer types
   // ------------------------------------------------------------
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
endpackage

// file: src/bcdr_regs.sv
`timescale 1ns/100ps
// Overview of operation
// RULE_01 - 8-bit buffer control, index 53h, reset 83h
// RULE_02 - bit 6 enables ide write posting
// RULE_03 - bit 5 keeps wc posting during hold
// RULE_04 - software enables bit 5 only for pci wc
// RULE_05 - 16-bit row type register, reset zero
// RULE_06 - bits 2n+1:2n describe dram row n
// RULE_07 - codes: edo, reserved, sdram, empty row
// RULE_08 - look up row type before each cycle
// RULE_09 - no cycles to empty rows; reserved writes ignored
module bcdr_regs #(
   parameter int ROWS = bcdr_pkg::ROW_COUNT
) (
   clk,
   srst,
   hsel,
   haddr,
   htrans,
   hwrite,
   hsize,
   hwdata,
   hready,
   hreadyout,
   hresp,
   hrdata,
   dram_req,
   dram_req_row,
   dram_start,
   dram_start_sdram,
   dram_reject,
   ide_io_write_post_enable,
   wc_post_during_bridge_hold_enable,
   bridge_bus_hold_ack_n,
   wc_write_pending,
   wc_post_allowed
);
   input  wire logic        clk;
   input  wire logic        srst;
   input  wire logic        hsel;
   input  wire logic [31:0] haddr;
   input  wire logic [1:0]  htrans;
   input  wire logic        hwrite;
   input  wire logic [2:0]  hsize;
   input  wire logic [31:0] hwdata;
   input  wire logic        hready;
   output logic             hreadyout;
   output logic             hresp;
   output logic      [31:0] hrdata;
   input  wire logic        dram_req;
   input  wire logic [2:0]  dram_req_row;
   output logic             dram_start;
   output logic             dram_start_sdram;
   output logic             dram_reject;
   output logic             ide_io_write_post_enable;
   output logic             wc_post_during_bridge_hold_enable;
   input  wire logic        bridge_bus_hold_ack_n;
   input  wire logic        wc_write_pending;
   output logic             wc_post_allowed;

   initial begin
      if (ROWS != bcdr_pkg::ROW_COUNT) begin
         $error("bcdr_regs: row type layout serves 8 rows only");
      end
   end

   // ------------------------------------------------------------
   // ahb address phase capture
   // ------------------------------------------------------------
   logic        wr_pend_q, wr_pend_d;
   logic [11:0] wr_addr_q, wr_addr_d;
   logic        addr_ok;

   always_comb begin
      addr_ok   = hsel && hready && (htrans == bcdr_pkg::HTRANS_NONSEQ);
      wr_pend_d = addr_ok && hwrite;
      wr_addr_d = wr_pend_d ? haddr[11:0] : wr_addr_q;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]  bufctl_q, bufctl_d;
   logic [15:0] rowtype_q, rowtype_d;

   always_comb begin
      bufctl_d  = bufctl_q;
      rowtype_d = rowtype_q;
      if (wr_pend_q && wr_addr_q == bcdr_pkg::ADDR_BUFCTL) begin
         // reserved bits keep their reset pattern
         bufctl_d = (hwdata[7:0] & bcdr_pkg::BUFCTL_RW_MASK) |
                    (bcdr_pkg::BUFCTL_RST & ~bcdr_pkg::BUFCTL_RW_MASK); // RULE_01
      end
      if (wr_pend_q && wr_addr_q == bcdr_pkg::ADDR_ROWTYPE) begin
         rowtype_d = hwdata[15:0]; // RULE_05
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bufctl_q  <= bcdr_pkg::BUFCTL_RST; // RULE_01
         rowtype_q <= bcdr_pkg::ROWTYPE_RST; // RULE_05
      end else begin
         bufctl_q  <= bufctl_d;
         rowtype_q <= rowtype_d;
      end
   end

   // ------------------------------------------------------------
   // read data and response
   // ------------------------------------------------------------
   logic [31:0] rdata_q, rdata_d;

   // reads use next values so a write just ahead is not seen stale
   always_comb begin
      rdata_d = rdata_q;
      if (addr_ok && !hwrite) begin
         case (haddr[11:0])
            bcdr_pkg::ADDR_BUFCTL:  rdata_d = {24'h000000, bufctl_d};
            bcdr_pkg::ADDR_ROWTYPE: rdata_d = {16'h0000, rowtype_d};
            default:                rdata_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q   <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         rdata_q   <= rdata_d;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_comb begin
      hrdata = rdata_q;
   end

   // ------------------------------------------------------------
   // dram cycle start control
   // ------------------------------------------------------------
   logic [1:0] row_code;
   logic       row_startable;
   logic       row_sdram;
   logic       start_d, sdram_d, reject_d;
   logic       start_q, sdram_q, reject_q;

   bcdr_row_lookup #(
      .ROWS  (bcdr_pkg::ROW_COUNT),
      .SEL_W (bcdr_pkg::ROW_SEL_W)
   ) u_lookup (
      .row_types (rowtype_q),
      .row_sel   (dram_req_row),
      .code      (row_code),
      .startable (row_startable),
      .is_sdram  (row_sdram)
   );

   always_comb begin
      start_d  = dram_req && row_startable; // RULE_08
      sdram_d  = dram_req && row_startable && row_sdram; // RULE_07
      reject_d = dram_req && !row_startable; // RULE_09
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         start_q  <= 1'b0;
         sdram_q  <= 1'b0;
         reject_q <= 1'b0;
      end else begin
         start_q  <= start_d;
         sdram_q  <= sdram_d;
         reject_q <= reject_d;
      end
   end

   // ------------------------------------------------------------
   // write posting control
   // ------------------------------------------------------------
   logic wc_ok_q, wc_ok_d;

   // posting stops while the bridge holds pci unless bit 5 is set
   always_comb begin
      wc_ok_d = wc_write_pending &&
                (bridge_bus_hold_ack_n ||
                 bufctl_q[bcdr_pkg::BUFCTL_WC_BIT]); // RULE_03
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wc_ok_q <= 1'b0;
      end else begin
         wc_ok_q <= wc_ok_d;
      end
   end

   always_comb begin
      dram_start                        = start_q;
      dram_start_sdram                  = sdram_q;
      dram_reject                       = reject_q;
      ide_io_write_post_enable          =
         bufctl_q[bcdr_pkg::BUFCTL_IDE_BIT]; // RULE_02
      wc_post_during_bridge_hold_enable =
         bufctl_q[bcdr_pkg::BUFCTL_WC_BIT]; // RULE_04
      wc_post_allowed                   = wc_ok_q;
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_wr_rowtype;
      addr_ok && hwrite && haddr[11:0] == bcdr_pkg::ADDR_ROWTYPE;
   endsequence

   sequence s_rd_rowtype;
      addr_ok && !hwrite && haddr[11:0] == bcdr_pkg::ADDR_ROWTYPE;
   endsequence

   AST_BUFCTL_RESET: assert property (@(posedge clk) // RULE_01
      srst |=> bufctl_q == 8'h83)
      else $error("buffer control not 83h after reset");

   AST_BUFCTL_RSVD: assert property (@(posedge clk) disable iff (srst) // RULE_01
      (bufctl_q & 8'h9f) == 8'h83)
      else $error("reserved buffer control bits changed");

   AST_IDE_OUT: assert property (@(posedge clk) disable iff (srst) // RULE_02
      (wr_pend_q && wr_addr_q == bcdr_pkg::ADDR_BUFCTL)
      |=> ide_io_write_post_enable == $past(hwdata[6]))
      else $error("ide posting enable not taken from write");

   AST_WC_GATE: assert property (@(posedge clk) disable iff (srst) // RULE_03
      ##1 wc_post_allowed == ($past(wc_write_pending) &&
         ($past(bridge_bus_hold_ack_n) || $past(bufctl_q[5]))))
      else $error("wc posting gate wrong");

   AST_ROWTYPE_RESET: assert property (@(posedge clk) // RULE_05
      srst |=> rowtype_q == 16'h0000 && hrdata == 32'h00000000)
      else $error("row type not cleared by reset");

   AST_ROWTYPE_WRITE: assert property (@(posedge clk) disable iff (srst) // RULE_05
      s_wr_rowtype ##1 1'b1 |=> rowtype_q == $past(hwdata[15:0]))
      else $error("row type write lost");

   AST_ROWTYPE_READ: assert property (@(posedge clk) disable iff (srst) // RULE_05
      s_rd_rowtype |=> hrdata == {16'h0000, rowtype_q})
      else $error("row type read mismatch");

   AST_ROW_PAIR: assert property (@(posedge clk) disable iff (srst) // RULE_06
      dram_req |-> row_code == rowtype_q[2*dram_req_row +: 2])
      else $error("row pair lookup wrong");

   AST_TIMING: assert property (@(posedge clk) disable iff (srst) // RULE_08
      dram_start |-> dram_start_sdram ==
         ($past(row_code) == bcdr_pkg::ROW_SDRAM))
      else $error("timing not matched to row type");

   AST_NO_EMPTY: assert property (@(posedge clk) disable iff (srst) // RULE_09
      dram_req && rowtype_q[2*dram_req_row +: 2] == 2'h3
      |=> !dram_start && dram_reject)
      else $error("cycle started to empty row");

   AST_ONE_ANSWER: assert property (@(posedge clk) disable iff (srst) // RULE_08
      dram_req |=> (dram_start ^ dram_reject))
      else $error("dram request not answered once");

   AST_BUS_OKAY: assert property (@(posedge clk) disable iff (srst)
      hreadyout && !hresp)
      else $error("bus answer not ready okay");
endmodule

// file: src/bcdr_row_lookup.sv
`timescale 1ns/100ps
module bcdr_row_lookup #(
   parameter int ROWS  = 8,
   parameter int SEL_W = 3
) (
   row_types,
   row_sel,
   code,
   startable,
   is_sdram
);
   input  wire logic [2*ROWS-1:0] row_types;
   input  wire logic [SEL_W-1:0]  row_sel;
   output logic      [1:0]        code;
   output logic                   startable;
   output logic                   is_sdram;

   initial begin
      if (ROWS < 1 || (1 << SEL_W) < ROWS) begin
         $error("bcdr_row_lookup: bad ROWS/SEL_W");
      end
   end

   // ------------------------------------------------------------
   // pair n of the row type field belongs to row n
   // ------------------------------------------------------------
   always_comb begin
      code = row_types[{row_sel, 1'b0} +: 2]; // RULE_06
      // reserved code treated like empty: timing is undefined for it
      startable = (code == bcdr_pkg::ROW_EDO) ||
                  (code == bcdr_pkg::ROW_SDRAM); // RULE_09
      is_sdram  = (code == bcdr_pkg::ROW_SDRAM); // RULE_07
   end
endmodule

// file: test/bcdr_regs_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module bcdr_regs_tb;
   // ------------------------------------------------------------
   // stimulus and dut
   // ------------------------------------------------------------
   logic        clk           = 1'b0;
   logic        srst          = 1'b1;
   logic        hsel          = 1'b0;
   logic [31:0] haddr         = 32'h0;
   logic [1:0]  htrans        = 2'h0;
   logic        hwrite        = 1'b0;
   logic [31:0] hwdata        = 32'h0;
   logic        dram_req      = 1'b0;
   logic [2:0]  dram_req_row  = 3'h0;
   logic        hold_ack_n    = 1'b1;
   logic        wc_pend       = 1'b0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        dram_start;
   logic        dram_start_sdram;
   logic        dram_reject;
   logic        ide_en;
   logic        wc_en;
   logic        wc_allowed;
   int          n_mismatch    = 0;
   int          checks        = 0;

   always #5 clk = ~clk;

   bcdr_regs u_dut (
      .clk                               (clk),
      .srst                              (srst),
      .hsel                              (hsel),
      .haddr                             (haddr),
      .htrans                            (htrans),
      .hwrite                            (hwrite),
      .hsize                             (3'h2),
      .hwdata                            (hwdata),
      .hready                            (hreadyout),
      .hreadyout                         (hreadyout),
      .hresp                             (hresp),
      .hrdata                            (hrdata),
      .dram_req                          (dram_req),
      .dram_req_row                      (dram_req_row),
      .dram_start                        (dram_start),
      .dram_start_sdram                  (dram_start_sdram),
      .dram_reject                       (dram_reject),
      .ide_io_write_post_enable          (ide_en),
      .wc_post_during_bridge_hold_enable (wc_en),
      .bridge_bus_hold_ack_n             (hold_ack_n),
      .wc_write_pending                  (wc_pend),
      .wc_post_allowed                   (wc_allowed)
   );

   // ------------------------------------------------------------
   // bus access and verdict
   // ------------------------------------------------------------
   // no wait count assumed: only the watchdog ends a stuck wait
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= {20'h0, a};
      htrans <= bcdr_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] rd;
      bus(1'b0, bcdr_pkg::ADDR_BUFCTL, 32'h0, rd);
      `CHK("buffer_ctl", 32'h83, rd)
      `CHK("ide_en", 1'b0, ide_en)
      `CHK("wc_en", 1'b0, wc_en)
      bus(1'b0, bcdr_pkg::ADDR_ROWTYPE, 32'h0, rd);
      `CHK("row_type", 32'h0, rd)
      bus(1'b1, 12'h150, 32'hffffffff, rd);
      bus(1'b0, 12'h150, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
   endtask

   task automatic t_bufctl;
      logic [31:0] rd;
      logic [31:0] wv[4] = '{32'hffffffff, 32'h40, 32'h20, 32'h0};
      foreach (wv[i]) begin
         bus(1'b1, bcdr_pkg::ADDR_BUFCTL, wv[i], rd);
         bus(1'b0, bcdr_pkg::ADDR_BUFCTL, 32'h0, rd);
         `CHK("buffer_ctl", (wv[i] & 32'h60) | 32'h83, rd)
         `CHK("ide_en", wv[i][6], ide_en)
         `CHK("wc_en", wv[i][5], wc_en)
      end
   endtask

   task automatic t_wc;
      logic [31:0] rd;
      logic [2:0]  s;
      for (int i = 0; i < 8; i++) begin
         s = 3'(i);
         // bit 5 set from s[2] on half the passes as if a wc region sat on pci
         bus(1'b1, bcdr_pkg::ADDR_BUFCTL, {26'h0, s[2], 5'h0}, rd);
         hold_ack_n <= s[1];
         wc_pend    <= s[0];
         repeat (2) @(posedge clk);
         #1;
         `CHK("wc_allowed", s[0] & (s[1] | s[2]), wc_allowed)
      end
   endtask

   task automatic t_rows;
      logic [31:0] rd;
      logic [15:0] v;
      logic [1:0]  cd;
      for (int c = 0; c < 4; c++) begin
         // every row sees every code once over the four passes
         for (int n = 0; n < 8; n++) v[2*n +: 2] = 2'((n + c) % 4);
         bus(1'b1, bcdr_pkg::ADDR_ROWTYPE, {16'h0, v}, rd);
         bus(1'b0, bcdr_pkg::ADDR_ROWTYPE, 32'h0, rd);
         `CHK("row_type", {16'h0, v}, rd)
         for (int n = 0; n < 8; n++) begin
            cd = v[2*n +: 2];
            dram_req     <= 1'b1;
            dram_req_row <= 3'(n);
            @(posedge clk);
            dram_req <= 1'b0;
            @(negedge clk);
            `CHK("start", !cd[0], dram_start)
            `CHK("sdram", cd == 2'h2, dram_start_sdram)
            `CHK("reject", cd[0], dram_reject)
            @(posedge clk);
         end
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      print_verdict;
   end

   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset;
      t_bufctl;
      t_wc;
      t_rows;
      print_verdict;
   end
endmodule
